// File: src/pob_bank.sv
// APB register bank holding the port option registers and the port logic they steer.
//
// Function
// - Only power-on reset loads defaults; else CPU writes.
// - Other resets leave option registers untouched.
// - Register 76 selects port A interrupt edge.
// - Register 77 removes port A pull-downs.
// - Register 78 disables port B pull-downs.
// - Register 7B routes clocks, enables sleep wake.
// - Registers 7C, 7D select port A reset sets.
// - Register 7E disables serial port pull-downs.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pob_consts.svh"

module pob_bank #(
  parameter int ADDR_W    = 12,
  parameter int OPT_W     = 4,
  parameter int HALF_1HZ  = `POB_CLK_HZ / (2 * `POB_F_ONE_HERTZ),
  parameter int HALF_1KHZ = `POB_CLK_HZ / (2 * `POB_F_KILOHERTZ),
  parameter int HALF_32K  = `POB_CLK_HZ / (2 * `POB_F_CRYSTAL)
) (
  input  wire logic              pclk,                   // System clock, 50 MHz.
  input  wire logic              presetn,                // Power-on reset, active low.
  input  wire logic              warm_reset,             // Watchdog, pin or port A reset pulse.
  input  wire logic [ADDR_W-1:0] paddr,                  // APB byte address.
  input  wire logic              psel,                   // APB select.
  input  wire logic              penable,                // APB access phase.
  input  wire logic              pwrite,                 // APB direction, high for write.
  input  wire logic [31:0]       pwdata,                 // APB write data.
  output logic [31:0]            prdata,                 // APB read data.
  output logic                   pready,                 // APB ready, never stalls.
  output logic                   pslverr,                // APB error for unmapped address.
  input  wire logic [3:0]        porta_pin,              // Port A input pins, asynchronous.
  input  wire logic              sleep_active,           // Device is in sleep mode.
  output pob_pkg::pob_opt_t      opt,                    // Current option settings.
  output pob_pkg::pob_freq_t     freq_out,               // Frequency outputs for port B.
  output logic [3:0]             porta_irq_event,        // Port A edge event pulses.
  output logic                   porta_combo_reset_req,  // Port A combination reset request.
  output logic                   sleep_wake_reset_req    // Reset request to leave sleep.
);
  import pob_pkg::*;

  // The nibble storage and decoder serve exactly four-bit options.
  if (OPT_W != 4 || ADDR_W < 10 || ADDR_W > 32) begin : g_bad
    $error("pob_bank: unsupported width parameter");
  end

  // Maps a byte address to a storage slot, the test slot or no slot.
  function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = 8'(addr[ADDR_W-1:2]);
    if (addr[ADDR_W-1:2] != (ADDR_W-2)'(idx) || addr[1:0] != 2'b00) begin
      slot_of = `POB_SLOT_NONE;
    end else if (idx >= `POB_IDX_DEBOUNCE && idx <= `POB_IDX_SP_PULL) begin
      slot_of = 4'(idx - `POB_IDX_DEBOUNCE);
    end else if (idx == `POB_IDX_TEST) begin
      slot_of = `POB_SLOT_TEST;
    end else begin
      slot_of = `POB_SLOT_NONE;
    end
  endfunction

  logic [OPT_W-1:0] opt_mem_reg [`POB_NUM_OPT];
  logic [3:0]       acc_slot;
  logic             wr_en;
  logic [OPT_W-1:0] rd_nib;
  logic [31:0]      prdata_reg;
  logic             pslverr_reg;

  // Decode the current address; writes land only at the access phase edge.
  assign acc_slot = slot_of(paddr);
  assign wr_en    = psel && penable && pwrite && (acc_slot < 4'(`POB_NUM_OPT));
  assign pready   = 1'b1;

  // Option storage: defaults only at power-on, later only CPU writes change it.
  for (genvar gi = 0; gi < `POB_NUM_OPT; gi++) begin : g_opt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        opt_mem_reg[gi] <= `POB_OPT_RST;
      end else if (wr_en && acc_slot == 4'(gi)) begin
        opt_mem_reg[gi] <= pwdata[OPT_W-1:0];
      end
    end
  end

  // Selects the stored nibble for a read; the test slot and holes read zero.
  always_comb begin
    rd_nib = '0;
    for (int i = 0; i < `POB_NUM_OPT; i++) begin
      if (acc_slot == 4'(i)) begin
        rd_nib = opt_mem_reg[i];
      end
    end
  end

  // Read data and error are captured in the setup cycle and shown in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= `POB_RD_ZERO;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= pwrite ? `POB_RD_ZERO : {28'h0, rd_nib};
      pslverr_reg <= (acc_slot == `POB_SLOT_NONE);
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // Option nibbles presented to the port logic.
  assign opt.porta_debounce_off       = opt_mem_reg[0];
  assign opt.porta_irq_edge           = opt_mem_reg[1];
  assign opt.porta_pulldown_off       = opt_mem_reg[2];
  assign opt.portb_pulldown_off       = opt_mem_reg[3];
  assign opt.portb_open_drain         = opt_mem_reg[4];
  assign opt.serial_port_open_drain   = opt_mem_reg[5];
  assign opt.freq_sel_and_wake        = opt_mem_reg[6];
  assign opt.reset_combo_set_one      = opt_mem_reg[7];
  assign opt.reset_combo_set_two      = opt_mem_reg[8];
  assign opt.serial_port_pulldown_off = opt_mem_reg[9];

  pob_freq_t wave;

  // Square wave source; a warm reset restarts it but not the options.
  pob_freq_gen #(
    .CNT_W     (25),
    .HALF_1HZ  (HALF_1HZ),
    .HALF_1KHZ (HALF_1KHZ),
    .HALF_32K  (HALF_32K)
  ) u_freq (
    .pclk       (pclk),
    .presetn    (presetn),
    .warm_reset (warm_reset),
    .wave       (wave)
  );

  pob_freq_t freq_reg;

  // Each wave reaches port B only while its select bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_reg <= '0;
    end else begin
      freq_reg.portb_one_hertz_out    <= wave.portb_one_hertz_out &&
                                         opt_mem_reg[6][`POB_FB_ONE_HERTZ];
      freq_reg.portb_kilohertz_out    <= wave.portb_kilohertz_out &&
                                         opt_mem_reg[6][`POB_FB_KILOHERTZ];
      freq_reg.portb_crystal_freq_out <= wave.portb_crystal_freq_out &&
                                         opt_mem_reg[6][`POB_FB_CRYSTAL];
    end
  end

  assign freq_out = freq_reg;

  logic [3:0] pa_meta_reg;
  logic [3:0] pa_sync_reg;
  logic [3:0] pa_last_reg;

  // Two-stage synchroniser for the port A pins, plus a delayed copy for edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_meta_reg <= 4'h0;
      pa_sync_reg <= 4'h0;
      pa_last_reg <= 4'h0;
    end else begin
      pa_meta_reg <= porta_pin;
      pa_sync_reg <= pa_meta_reg;
      pa_last_reg <= pa_sync_reg;
    end
  end

  logic [3:0] pa_rise;
  logic [3:0] pa_fall;
  logic [3:0] irq_ev_reg;

  assign pa_rise = pa_sync_reg & ~pa_last_reg;
  assign pa_fall = ~pa_sync_reg & pa_last_reg;

  // A cleared edge bit reacts to a rising edge, a set bit to a falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ev_reg <= 4'h0;
    end else begin
      irq_ev_reg <= (pa_rise & ~opt_mem_reg[1]) | (pa_fall & opt_mem_reg[1]);
    end
  end

  assign porta_irq_event = irq_ev_reg;

  logic combo_one_hit;
  logic combo_two_hit;
  logic combo_req_reg;
  logic wake_req_reg;

  // A non-empty set hits when all its selected inputs are high together.
  assign combo_one_hit = (opt_mem_reg[7] != 4'h0) &&
                         ((pa_sync_reg & opt_mem_reg[7]) == opt_mem_reg[7]);
  assign combo_two_hit = (opt_mem_reg[8] != 4'h0) &&
                         ((pa_sync_reg & opt_mem_reg[8]) == opt_mem_reg[8]);

  // Combination reset request follows the hits with one cycle of delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      combo_req_reg <= 1'b0;
    end else begin
      combo_req_reg <= combo_one_hit || combo_two_hit;
    end
  end

  // In sleep, a rising port A edge asks for a reset when the wake bit is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= sleep_active && opt_mem_reg[6][`POB_FB_SLEEP_WAKE] && (|pa_rise);
    end
  end

  assign porta_combo_reset_req = combo_req_reg;
  assign sleep_wake_reset_req  = wake_req_reg;

  // Setup cycle of a write or a read to a given index.
  sequence s_setup_wr(logic [7:0] idx);
    psel && !penable && pwrite && paddr == ADDR_W'({idx, 2'b00});
  endsequence

  sequence s_setup_rd(logic [7:0] idx);
    psel && !penable && !pwrite && paddr == ADDR_W'({idx, 2'b00});
  endsequence

  // A complete write: setup then access with the same request.
  sequence s_write(logic [7:0] idx);
    s_setup_wr(idx) ##1 (psel && penable && pwrite && paddr == ADDR_W'({idx, 2'b00}));
  endsequence

  property p_hold_without_write;
    @(posedge pclk) disable iff (!presetn)
      !wr_en |=> ($stable(opt));
  endproperty
  a_hold_without_write: assert property (p_hold_without_write)
    else $error("option changed without a write");

  property p_warm_keeps;
    @(posedge pclk) disable iff (!presetn)
      (warm_reset && !wr_en) |=> $stable(opt) ##1 !freq_out.portb_crystal_freq_out;
  endproperty
  a_warm_keeps: assert property (p_warm_keeps)
    else $error("warm reset disturbed the options");

  property p_edge_write;
    @(posedge pclk) disable iff (!presetn)
      s_write(`POB_IDX_IRQ_EDGE) |=> (opt.porta_irq_edge == $past(pwdata[3:0]));
  endproperty
  a_edge_write: assert property (p_edge_write)
    else $error("edge select not written");

  property p_edge_rise;
    @(posedge pclk) disable iff (!presetn)
      (pa_rise[0] && !opt_mem_reg[1][0]) |=> porta_irq_event[0] ##1 !porta_irq_event[0];
  endproperty
  a_edge_rise: assert property (p_edge_rise)
    else $error("rising edge event missing");

  property p_pa_pull_write;
    @(posedge pclk) disable iff (!presetn)
      s_write(`POB_IDX_PA_PULL) |=> (opt.porta_pulldown_off == $past(pwdata[3:0]));
  endproperty
  a_pa_pull_write: assert property (p_pa_pull_write)
    else $error("port A pull select not written");

  property p_pb_pull_write;
    @(posedge pclk) disable iff (!presetn)
      s_write(`POB_IDX_PB_PULL) |=> (opt.portb_pulldown_off == $past(pwdata[3:0]));
  endproperty
  a_pb_pull_write: assert property (p_pb_pull_write)
    else $error("port B pull select not written");

  property p_freq_gate;
    @(posedge pclk) disable iff (!presetn)
      !opt_mem_reg[6][`POB_FB_KILOHERTZ] [*2] |-> !freq_out.portb_kilohertz_out;
  endproperty
  a_freq_gate: assert property (p_freq_gate)
    else $error("kilohertz output active while deselected");

  property p_combo_req;
    @(posedge pclk) disable iff (!presetn)
      (combo_one_hit || combo_two_hit) |=> porta_combo_reset_req;
  endproperty
  a_combo_req: assert property (p_combo_req)
    else $error("combination reset not requested");

  property p_sp_pull_write;
    @(posedge pclk) disable iff (!presetn)
      s_write(`POB_IDX_SP_PULL) |=> (opt.serial_port_pulldown_off == $past(pwdata[3:0]));
  endproperty
  a_sp_pull_write: assert property (p_sp_pull_write)
    else $error("serial port pull select not written");

  property p_read_back;
    @(posedge pclk) disable iff (!presetn)
      s_setup_rd(`POB_IDX_COMBO_TWO) |=> (prdata == {28'h0, $past(opt.reset_combo_set_two)} && !pslverr);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data differs from stored value");

endmodule
`default_nettype wire

// File: src/pob_consts.svh
// Constants for the port option register bank: indices, fields, reset values and rates.
`ifndef POB_CONSTS_SVH
`define POB_CONSTS_SVH

// Register indices; the byte address of each register is four times its index.
`define POB_IDX_DEBOUNCE     8'h75
`define POB_IDX_IRQ_EDGE     8'h76
`define POB_IDX_PA_PULL      8'h77
`define POB_IDX_PB_PULL      8'h78
`define POB_IDX_PB_OPEN      8'h79
`define POB_IDX_SP_OPEN      8'h7A
`define POB_IDX_FREQ_WAKE    8'h7B
`define POB_IDX_COMBO_ONE    8'h7C
`define POB_IDX_COMBO_TWO    8'h7D
`define POB_IDX_SP_PULL      8'h7E
`define POB_IDX_TEST         8'h7F

// Storage geometry and decoder answers.
`define POB_NUM_OPT          10
`define POB_SLOT_TEST        4'hA
`define POB_SLOT_NONE        4'hF
`define POB_OPT_RST          4'h0
`define POB_RD_ZERO          32'h0000_0000

// Bit positions inside the frequency output and sleep wake register.
`define POB_FB_ONE_HERTZ     0
`define POB_FB_KILOHERTZ     1
`define POB_FB_CRYSTAL       2
`define POB_FB_SLEEP_WAKE    3

// System clock and generated output frequencies in hertz.
`define POB_CLK_HZ           50000000
`define POB_F_ONE_HERTZ      1
`define POB_F_KILOHERTZ      1000
`define POB_F_CRYSTAL        32768

`endif

// File: src/pob_freq_gen.sv
// Divider that makes the 1 Hz, 1 kHz and 32 kHz square waves for port B.
`timescale 1ns/1ps
`default_nettype none
`include "pob_consts.svh"

module pob_freq_gen #(
  parameter int CNT_W     = 25,
  parameter int HALF_1HZ  = `POB_CLK_HZ / (2 * `POB_F_ONE_HERTZ),
  parameter int HALF_1KHZ = `POB_CLK_HZ / (2 * `POB_F_KILOHERTZ),
  parameter int HALF_32K  = `POB_CLK_HZ / (2 * `POB_F_CRYSTAL)
) (
  input  wire logic          pclk,       // System clock.
  input  wire logic          presetn,    // Power-on reset, active low.
  input  wire logic          warm_reset, // Watchdog, pin or port A reset.
  output pob_pkg::pob_freq_t wave        // Free running square waves.
);
  import pob_pkg::*;

  localparam int NUM_DIV = 3;
  localparam int HALF_TAB [NUM_DIV] = '{HALF_1HZ, HALF_1KHZ, HALF_32K};

  // Refuse half periods that do not fit the counter or are empty.
  if (HALF_1HZ < 1 || HALF_1KHZ < 1 || HALF_32K < 1 || HALF_1HZ >= (2 ** CNT_W) ||
      HALF_1KHZ >= (2 ** CNT_W) || HALF_32K >= (2 ** CNT_W)) begin : g_bad
    $error("pob_freq_gen: half period out of range");
  end

  logic [NUM_DIV-1:0] wave_reg;

  // One counter per divider; each toggles its wave at the end of a half period.
  for (genvar gi = 0; gi < NUM_DIV; gi++) begin : g_div
    logic [CNT_W-1:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg     <= '0;
        wave_reg[gi] <= 1'b0;
      end else if (warm_reset) begin
        cnt_reg     <= '0;
        wave_reg[gi] <= 1'b0;
      end else if (cnt_reg == CNT_W'(HALF_TAB[gi] - 1)) begin
        cnt_reg     <= '0;
        wave_reg[gi] <= ~wave_reg[gi];
      end else begin
        cnt_reg     <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // Divider 0 makes the slowest wave, divider 2 the fastest.
  assign wave.portb_one_hertz_out    = wave_reg[0];
  assign wave.portb_kilohertz_out    = wave_reg[1];
  assign wave.portb_crystal_freq_out = wave_reg[2];

endmodule
`default_nettype wire

// File: src/pob_pkg.sv
// Types shared by the port option register bank.
package pob_pkg;

  // Decoded option nibbles, in register order.
  typedef struct packed {
    logic [3:0] porta_debounce_off;
    logic [3:0] porta_irq_edge;
    logic [3:0] porta_pulldown_off;
    logic [3:0] portb_pulldown_off;
    logic [3:0] portb_open_drain;
    logic [3:0] serial_port_open_drain;
    logic [3:0] freq_sel_and_wake;
    logic [3:0] reset_combo_set_one;
    logic [3:0] reset_combo_set_two;
    logic [3:0] serial_port_pulldown_off;
  } pob_opt_t;

  // Frequency outputs routed to port B.
  typedef struct packed {
    logic portb_one_hertz_out;
    logic portb_kilohertz_out;
    logic portb_crystal_freq_out;
  } pob_freq_t;

endpackage

// File: verification/tb_port_option_register_bank.sv
// Self-checking testbench for the port option register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pob_consts.svh"

module tb_port_option_register_bank;
  import pob_pkg::*;

  localparam int H1 = 8;
  localparam int H2 = 4;
  localparam int H3 = 2;
  localparam logic [7:0] IDX [10] = '{`POB_IDX_DEBOUNCE, `POB_IDX_IRQ_EDGE, `POB_IDX_PA_PULL, `POB_IDX_PB_PULL,
    `POB_IDX_PB_OPEN, `POB_IDX_SP_OPEN, `POB_IDX_FREQ_WAKE, `POB_IDX_COMBO_ONE, `POB_IDX_COMBO_TWO, `POB_IDX_SP_PULL};

  logic        pclk;
  logic        presetn;
  logic        warm_reset;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  porta_pin;
  logic        sleep_active;
  pob_opt_t    opt;
  pob_freq_t   freq_out;
  logic [3:0]  porta_irq_event;
  logic        porta_combo_reset_req;
  logic        sleep_wake_reset_req;
  int          n_fail;
  int          num_checks;
  logic [32:0] exp_q[$];
  logic        exp_werr_q[$];
  logic [3:0]  shadow[10];
  logic [3:0]  ev_seen;
  logic        combo_seen;
  logic        wake_seen;
  logic [2:0]  wave_seen;

  pob_bank #(.HALF_1HZ(H1), .HALF_1KHZ(H2), .HALF_32K(H3)) uut (
    .pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .porta_pin(porta_pin), .sleep_active(sleep_active), .opt(opt),
    .freq_out(freq_out), .porta_irq_event(porta_irq_event), .porta_combo_reset_req(porta_combo_reset_req),
    .sleep_wake_reset_req(sleep_wake_reset_req));

  // The clock toggles every half period of 10 ns.
  always #10 pclk = ~pclk;

  // Compares a seen value with an expected one and counts the result.
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Checks made: %0d, mismatches: %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Byte address of a register index.
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Expected option bundle built from the software shadow copy.
  function automatic pob_opt_t exp_opt();
    return {shadow[0], shadow[1], shadow[2], shadow[3], shadow[4], shadow[5], shadow[6], shadow[7], shadow[8],
      shadow[9]};
  endfunction

  // One APB transfer; the request is held until pready is seen high, then released for one idle cycle.
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Notes the expected answer of a read and issues it.
  task automatic rd(input logic [11:0] a, input logic [3:0] d, input logic err);
    exp_q.push_back({err, 28'h0, d});
    apb(a, 1'b0, $urandom);
  endtask

  // Notes the expected error answer of a write and issues it.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    exp_werr_q.push_back(err);
    apb(a, 1'b1, d);
  endtask

  // Writes an option nibble with random upper bits and updates the shadow.
  task automatic wr_opt(input int i, input logic [3:0] v);
    shadow[i] = v;
    wr(ba(IDX[i]), {28'($urandom), v}, 1'b0);
  endtask

  // Reads every option register back and compares the bundle.
  task automatic read_all();
    for (int i = 0; i < 10; i++) rd(ba(IDX[i]), shadow[i], 1'b0);
    check("opt bundle", 40'(opt), 40'(exp_opt()));
  endtask

  // Collects port activity over n cycles, sampled mid-cycle.
  task automatic watch(input int n);
    ev_seen = 4'h0;
    combo_seen = 1'b0;
    wake_seen = 1'b0;
    wave_seen = 3'h0;
    repeat (n) begin
      @(negedge pclk);
      ev_seen |= porta_irq_event;
      combo_seen |= porta_combo_reset_req;
      wake_seen |= sleep_wake_reset_req;
      wave_seen |= freq_out;
    end
    @(posedge pclk);
  endtask

  // Takes the oldest noted read answer whenever a read completes.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        check("unexpected read", 40'h1, 40'h0);
      end else begin
        check("read answer", 40'({pslverr, prdata}), 40'(exp_q.pop_front()));
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (exp_werr_q.size() == 0) begin
        check("unexpected write", 40'h1, 40'h0);
      end else begin
        check("write error", 40'(pslverr), 40'(exp_werr_q.pop_front()));
      end
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #400000;
    n_fail++;
    summarize();
  end

  // Main sequence.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    warm_reset = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    porta_pin = 4'h0;
    sleep_active = 1'b0;
    n_fail = 0;
    num_checks = 0;
    foreach (shadow[i]) shadow[i] = `POB_OPT_RST;
    void'($urandom(50485));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_all();
    rd(ba(`POB_IDX_TEST), 4'h0, 1'b0);
    rd(12'h000, 4'h0, 1'b1);
    $display("Test reset defaults done");
    for (int i = 0; i < 10; i++) wr_opt(i, 4'($urandom));
    wr(ba(`POB_IDX_TEST), $urandom, 1'b0);
    wr(12'h004, $urandom, 1'b1);
    read_all();
    check("irq edge field", 33'(opt.porta_irq_edge), 33'(shadow[1]));
    check("port a pull field", 33'(opt.porta_pulldown_off), 33'(shadow[2]));
    check("port b pull field", 33'(opt.portb_pulldown_off), 33'(shadow[3]));
    check("freq wake field", 33'(opt.freq_sel_and_wake), 33'(shadow[6]));
    check("combo two field", 33'(opt.reset_combo_set_two), 33'(shadow[8]));
    check("serial pull field", 33'(opt.serial_port_pulldown_off), 33'(shadow[9]));
    $display("Test write and read back done");
    warm_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    warm_reset <= 1'b0;
    @(posedge pclk);
    read_all();
    $display("Test warm reset done");
    for (int i = 0; i < 10; i++) wr_opt(i, 4'h0);
    wr_opt(1, 4'hA);
    porta_pin <= 4'hF;
    watch(8);
    check("rising events", 33'(ev_seen), 33'h5);
    porta_pin <= 4'h0;
    watch(8);
    check("falling events", 33'(ev_seen), 33'hA);
    $display("Test interrupt edge done");
    wr_opt(7, 4'h3);
    porta_pin <= 4'h3;
    watch(6);
    check("combo one request", 33'(combo_seen), 33'h1);
    porta_pin <= 4'h1;
    watch(6);
    check("combo one partial", 33'(porta_combo_reset_req), 33'h0);
    wr_opt(7, 4'h0);
    wr_opt(8, 4'hC);
    porta_pin <= 4'hC;
    watch(6);
    check("combo two request", 33'(combo_seen), 33'h1);
    porta_pin <= 4'h0;
    wr_opt(8, 4'h0);
    watch(6);
    check("combo cleared", 33'(combo_seen), 33'h0);
    $display("Test reset combination done");
    wr_opt(6, 4'h8);
    sleep_active <= 1'b1;
    @(posedge pclk);
    porta_pin <= 4'h1;
    watch(6);
    check("sleep wake pulse", 33'(wake_seen), 33'h1);
    wr_opt(6, 4'h0);
    porta_pin <= 4'h0;
    watch(4);
    porta_pin <= 4'h2;
    watch(6);
    check("sleep wake disabled", 33'(wake_seen), 33'h0);
    sleep_active <= 1'b0;
    porta_pin <= 4'h0;
    $display("Test sleep wake done");
    wr_opt(6, 4'h7);
    watch(40);
    check("frequency outputs", 33'(wave_seen), 33'h7);
    wr_opt(6, 4'h0);
    watch(4);
    watch(40);
    check("frequency outputs off", 33'(wave_seen), 33'h0);
    $display("Test frequency outputs done");
    for (int i = 0; i < 10; i++) wr_opt(i, 4'($urandom) | 4'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (shadow[i]) shadow[i] = `POB_OPT_RST;
    read_all();
    $display("Test power-on reset again done");
    repeat (3) @(posedge pclk);
    check("pending answers", 40'(exp_q.size() + exp_werr_q.size()), 40'h0);
    summarize();
  end

endmodule
`default_nettype wire
